/* File: logic/cbf_pkg.sv */
// Shared constants and types for the CAN buffer, filter and fault counter block
package cbf_pkg;
  localparam int NUM_BUF       = 3;
  localparam int NUM_FILT      = 2;
  localparam int NUM_BYTES     = 8;
  localparam int ADDR_W        = 12;
  // Register byte offsets, one aligned word each
  localparam logic [11:0] OFS_TEC       = 12'h000;
  localparam logic [11:0] OFS_REC       = 12'h004;
  localparam logic [11:0] OFS_CONFIG    = 12'h008;
  localparam logic [11:0] OFS_RECEIVE_IRQ_FLAG      = 12'h00C;
  localparam logic [11:0] OFS_FILT_BASE = 12'h010;
  localparam logic [11:0] FILT_STRIDE   = 12'h010;
  localparam logic [11:0] OFS_FLT_HI    = 12'h000;
  localparam logic [11:0] OFS_FLT_LO    = 12'h004;
  localparam logic [11:0] OFS_MSK_HI    = 12'h008;
  localparam logic [11:0] OFS_MSK_LO    = 12'h00C;
  localparam logic [11:0] OFS_BUF_BASE  = 12'h040;
  localparam logic [11:0] BUF_STRIDE    = 12'h040;
  localparam logic [11:0] OFS_ID_HI     = 12'h000;
  localparam logic [11:0] OFS_ID_LO     = 12'h004;
  localparam logic [11:0] OFS_DATA0     = 12'h008;
  localparam logic [11:0] OFS_BCSR      = 12'h028;
  // Control/status bit positions
  localparam int BCSR_LOCK     = 0;
  localparam int BCSR_BUSY     = 1;
  localparam int BCSR_RDY      = 2;
  localparam int BCSR_ACC      = 3;
  localparam int CFG_EARLY_TX  = 0;
  localparam logic [2:0] LAST_BYTE = 3'h7;
  // Fault confinement figures
  localparam logic [8:0] TEC_STEP_ERR  = 9'h008;
  localparam logic [8:0] TEC_BUS_OFF   = 9'h100;
  localparam logic [7:0] PASSIVE_LIMIT = 8'h7F;
  localparam logic [7:0] REC_STEP_MIN  = 8'h01;
  localparam logic [7:0] REC_STEP_MAX  = 8'h08;
  localparam logic [7:0] REC_HIGH      = 8'h80;
  localparam logic [7:0] REC_RELOAD    = 8'h78;
  localparam logic [7:0] REC_MAX       = 8'hFF;

  typedef struct packed {
    logic [10:0]    message_ident;
    logic           rtr;
    logic [3:0]     dlc;
    logic [63:0]    payload;
  } cbf_frame_s;

  typedef struct packed {
    logic           tx_err;
    logic           tx_ok;
    logic           rx_err;
    logic           rx_err_severe;
  } cbf_fault_ev_s;
endpackage

/* File: logic/cbf_core.sv */
// Paged CAN message buffers, acceptance filters and fault confinement counters
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
module cbf_core (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire cbf_pkg::cbf_fault_ev_s fault_ev,
  input  wire logic                  rx_start,
  input  wire logic [11:0]           rx_key,
  input  wire logic                  rx_done,
  input  wire logic                  rx_abort,
  input  wire cbf_pkg::cbf_frame_s   rx_frame,
  output logic                       rx_stored,
  input  wire logic                  tx_start,
  input  wire logic [1:0]            tx_sel,
  input  wire logic                  tx_arb_won,
  input  wire logic                  tx_done,
  input  wire logic                  tx_abort,
  output logic      [2:0]            tx_request,
  output cbf_pkg::cbf_frame_s        tx_frame,
  output logic                       tx_irq,
  output logic      [2:0]            receive_irq_flag,
  input  wire logic [2:0]            receive_irq_flag_clear,
  output logic                       error_passive,
  output logic                       bus_off
);
  typedef enum {
    CBF_IDLE,
    CBF_RX,
    CBF_TX
  } cbf_core_e;

  logic [8:0]                        tx_fault_tally;
  logic [7:0]                        rx_fault_tally;
  logic                              early_transmit_mode;
  logic [11:0]                       filter_bits [cbf_pkg::NUM_FILT];
  logic [11:0]                       mask_bits [cbf_pkg::NUM_FILT];
  cbf_pkg::cbf_frame_s               buf_frame [cbf_pkg::NUM_BUF];
  logic [2:0]                        lock;
  logic [2:0]                        ready;
  logic [2:0]                        accepting_filter_code;
  cbf_core_e                         state;
  logic [1:0]                        cur_buf;
  logic                              cur_acc;
  logic                              cur_valid;

  // Access decode
  logic                              acc;
  logic                              wr;
  logic                              hit;
  logic [11:0]                       ofs;
  logic [1:0]                        sel_buf;
  logic                              sel_filt;
  logic                              is_buf;
  logic                              is_filt;
  logic [11:0]                       rel;
  logic [7:0]                        wbyte;
  logic [2:0]                        byte_idx;

  function automatic logic filt_match(input logic [11:0] filt, input logic [11:0] msk, input logic [11:0] key);
    filt_match = (((filt ^ key) & msk) == 12'h000);
  endfunction

  function automatic logic [11:0] buf_ofs(input logic [1:0] idx);
    buf_ofs = cbf_pkg::OFS_BUF_BASE + cbf_pkg::BUF_STRIDE * {10'h000, idx};
  endfunction

  assign acc   = psel && penable;
  assign wr    = acc && pwrite;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;

  always_comb begin
    ofs      = {paddr[11:2], 2'b00};
    is_buf   = 1'b0;
    is_filt  = 1'b0;
    sel_buf  = 2'h0;
    sel_filt = 1'b0;
    rel      = 12'h000;
    for (int b = 0; b < cbf_pkg::NUM_BUF; b++) begin
      if (ofs >= buf_ofs(2'(b)) && ofs <= buf_ofs(2'(b)) + cbf_pkg::OFS_BCSR) begin
        is_buf  = 1'b1;
        sel_buf = 2'(b);
        rel     = ofs - buf_ofs(2'(b));
      end
    end
    for (int f = 0; f < cbf_pkg::NUM_FILT; f++) begin
      if (ofs >= cbf_pkg::OFS_FILT_BASE + cbf_pkg::FILT_STRIDE * 12'(f) &&
          ofs <= cbf_pkg::OFS_FILT_BASE + cbf_pkg::FILT_STRIDE * 12'(f) + cbf_pkg::OFS_MSK_LO) begin
        is_filt  = 1'b1;
        sel_filt = 1'(f);
        rel      = ofs - cbf_pkg::OFS_FILT_BASE - cbf_pkg::FILT_STRIDE * 12'(f);
      end
    end
    byte_idx = 3'(rel[11:2] - cbf_pkg::OFS_DATA0[11:2]);
    hit = is_buf || is_filt || ofs == cbf_pkg::OFS_TEC || ofs == cbf_pkg::OFS_REC ||
          ofs == cbf_pkg::OFS_CONFIG || ofs == cbf_pkg::OFS_RECEIVE_IRQ_FLAG;
  end

  // Read mux
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = acc && !hit;
    if (acc && !pwrite && hit) begin
      if (is_buf) begin
        if (rel == cbf_pkg::OFS_ID_HI)
          prdata[7:0] = buf_frame[sel_buf].message_ident[10:3];
        else if (rel == cbf_pkg::OFS_ID_LO)
          prdata[7:0] = {buf_frame[sel_buf].message_ident[2:0], buf_frame[sel_buf].rtr,
                         buf_frame[sel_buf].dlc};
        else if (rel == cbf_pkg::OFS_BCSR) begin
          prdata[cbf_pkg::BCSR_LOCK] = lock[sel_buf];
          prdata[cbf_pkg::BCSR_BUSY] = cur_valid && cur_buf == sel_buf;
          prdata[cbf_pkg::BCSR_RDY]  = ready[sel_buf];
          prdata[cbf_pkg::BCSR_ACC]  = accepting_filter_code[sel_buf];
        end else
          prdata[7:0] = buf_frame[sel_buf].payload[byte_idx*8 +: 8];
      end else if (is_filt) begin
        unique case (rel)
          cbf_pkg::OFS_FLT_HI: prdata[7:0] = filter_bits[sel_filt][11:4];
          cbf_pkg::OFS_FLT_LO: prdata[7:0] = {filter_bits[sel_filt][3:0], 4'h0};
          cbf_pkg::OFS_MSK_HI: prdata[7:0] = mask_bits[sel_filt][11:4];
          default:             prdata[7:0] = {mask_bits[sel_filt][3:0], 4'h0};
        endcase
      end else if (ofs == cbf_pkg::OFS_TEC)
        prdata[7:0] = tx_fault_tally[7:0];
      else if (ofs == cbf_pkg::OFS_REC)
        prdata[7:0] = rx_fault_tally;
      else if (ofs == cbf_pkg::OFS_CONFIG)
        prdata[cbf_pkg::CFG_EARLY_TX] = early_transmit_mode;
      else
        prdata[2:0] = receive_irq_flag;
    end
  end

  // Software and transfer strobes per buffer
  logic [2:0]                        sw_rdy_clr;
  logic [2:0]                        sw_lock_wr;
  logic [2:0]                        sw_tx_req;
  logic [2:0]                        sw_receive_irq_flag_clr;
  logic [2:0]                        busy;
  logic [2:0]                        rx_fill_ok;
  logic [2:0]                        tx_ok_buf;

  always_comb begin
    for (int b = 0; b < cbf_pkg::NUM_BUF; b++) begin
      busy[b]        = cur_valid && cur_buf == 2'(b);
      sw_rdy_clr[b]  = wr && is_buf && sel_buf == 2'(b) && rel == cbf_pkg::OFS_BCSR &&
                       !wbyte[cbf_pkg::BCSR_RDY] && !lock[b];
      sw_lock_wr[b]  = wr && is_buf && sel_buf == 2'(b) && rel == cbf_pkg::OFS_BCSR && !busy[b];
      sw_tx_req[b]   = wr && is_buf && sel_buf == 2'(b) && rel >= cbf_pkg::OFS_DATA0 &&
                       rel < cbf_pkg::OFS_BCSR && byte_idx == cbf_pkg::LAST_BYTE && lock[b];
      sw_receive_irq_flag_clr[b] = (wr && ofs == cbf_pkg::OFS_RECEIVE_IRQ_FLAG && wbyte[b]) || receive_irq_flag_clear[b];
      rx_fill_ok[b]  = rx_done && state == CBF_RX && busy[b];
      tx_ok_buf[b]   = tx_done && state == CBF_TX && busy[b];
    end
  end

  // First free unlocked buffer and accepting filter for an incoming header
  logic                              rx_hit;
  logic                              rx_free;
  logic [1:0]                        rx_pick;
  always_comb begin
    rx_hit  = filt_match(filter_bits[0], mask_bits[0], rx_key) ||
              filt_match(filter_bits[1], mask_bits[1], rx_key);
    rx_free = 1'b0;
    rx_pick = 2'h0;
    for (int b = cbf_pkg::NUM_BUF - 1; b >= 0; b--) begin
      if (!lock[b] && !ready[b]) begin
        rx_free = 1'b1;
        rx_pick = 2'(b);
      end
    end
  end

  // Core transfer sequencing, owns the busy buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= CBF_IDLE;
      cur_buf   <= 2'h0;
      cur_acc   <= 1'b0;
      cur_valid <= 1'b0;
    end else begin
      unique case (state)
        CBF_IDLE: begin
          if (tx_start && lock[tx_sel] && ready[tx_sel]) begin
            state     <= CBF_TX;
            cur_buf   <= tx_sel;
            cur_valid <= 1'b1;
          end else if (rx_start && rx_hit && rx_free) begin
            state     <= CBF_RX;
            cur_buf   <= rx_pick;
            cur_acc   <= !filt_match(filter_bits[0], mask_bits[0], rx_key);
            cur_valid <= 1'b1;
          end
        end
        CBF_RX, CBF_TX: begin
          if ((state == CBF_RX && (rx_done || rx_abort)) || (state == CBF_TX && (tx_done || tx_abort))) begin
            state     <= CBF_IDLE;
            cur_valid <= 1'b0;
          end
        end
      endcase
    end
  end

  // Buffer contents: software writes and received frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < cbf_pkg::NUM_BUF; b++)
        buf_frame[b] <= '0;
    end else begin
      for (int b = 0; b < cbf_pkg::NUM_BUF; b++) begin
        if (rx_fill_ok[b])
          buf_frame[b] <= rx_frame;
        else if (wr && is_buf && sel_buf == 2'(b)) begin
          if (rel == cbf_pkg::OFS_ID_HI)
            buf_frame[b].message_ident[10:3] <= wbyte;
          else if (rel == cbf_pkg::OFS_ID_LO) begin
            buf_frame[b].message_ident[2:0] <= wbyte[7:5];
            buf_frame[b].rtr                <= wbyte[4];
            buf_frame[b].dlc                <= wbyte[3:0];
          end else if (rel != cbf_pkg::OFS_BCSR)
            buf_frame[b].payload[byte_idx*8 +: 8] <= wbyte;
        end
      end
    end
  end

  // Lock, ready, acceptance code and receive flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock                  <= 3'h0;
      ready                 <= 3'h0;
      accepting_filter_code <= 3'h0;
      receive_irq_flag      <= 3'h0;
    end else begin
      for (int b = 0; b < cbf_pkg::NUM_BUF; b++) begin
        if (tx_ok_buf[b] && early_transmit_mode)
          lock[b] <= 1'b0;
        else if (sw_lock_wr[b])
          lock[b] <= wbyte[cbf_pkg::BCSR_LOCK];
        if (rx_fill_ok[b] || sw_tx_req[b])
          ready[b] <= 1'b1;
        else if (sw_rdy_clr[b] || tx_ok_buf[b] || (sw_lock_wr[b] && lock[b] && !wbyte[cbf_pkg::BCSR_LOCK]))
          ready[b] <= 1'b0;
        if (rx_fill_ok[b])
          receive_irq_flag[b] <= 1'b1;
        else if (sw_rdy_clr[b] || sw_receive_irq_flag_clr[b])
          receive_irq_flag[b] <= 1'b0;
        if (rx_fill_ok[b])
          accepting_filter_code[b] <= cur_acc;
        else if (sw_rdy_clr[b] || sw_receive_irq_flag_clr[b] || tx_ok_buf[b] ||
                 (sw_lock_wr[b] && lock[b] && !wbyte[cbf_pkg::BCSR_LOCK]))
          accepting_filter_code[b] <= 1'b0;
      end
    end
  end

  // Filters, masks and mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_transmit_mode <= 1'b0;
      for (int f = 0; f < cbf_pkg::NUM_FILT; f++) begin
        filter_bits[f] <= 12'h000;
        mask_bits[f]   <= 12'h000;
      end
    end else begin
      if (wr && ofs == cbf_pkg::OFS_CONFIG)
        early_transmit_mode <= wbyte[cbf_pkg::CFG_EARLY_TX];
      if (wr && is_filt) begin
        unique case (rel)
          cbf_pkg::OFS_FLT_HI: filter_bits[sel_filt][11:4] <= wbyte;
          cbf_pkg::OFS_FLT_LO: filter_bits[sel_filt][3:0]  <= wbyte[7:4];
          cbf_pkg::OFS_MSK_HI: mask_bits[sel_filt][11:4]   <= wbyte;
          default:             mask_bits[sel_filt][3:0]    <= wbyte[7:4];
        endcase
      end
    end
  end

  // Transmit error counter; saturates at bus-off until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_fault_tally <= 9'h000;
    else if (!bus_off) begin
      if (fault_ev.tx_err)
        tx_fault_tally <= (tx_fault_tally + cbf_pkg::TEC_STEP_ERR > cbf_pkg::TEC_BUS_OFF) ?
                          cbf_pkg::TEC_BUS_OFF : tx_fault_tally + cbf_pkg::TEC_STEP_ERR;
      else if (fault_ev.tx_ok && tx_fault_tally != 9'h000)
        tx_fault_tally <= tx_fault_tally - 9'h001;
    end
  end

  // Receive error counter, held at its top value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rx_fault_tally <= 8'h00;
    else if (fault_ev.rx_err) begin
      if (fault_ev.rx_err_severe)
        rx_fault_tally <= (rx_fault_tally > cbf_pkg::REC_MAX - cbf_pkg::REC_STEP_MAX) ?
                          cbf_pkg::REC_MAX : rx_fault_tally + cbf_pkg::REC_STEP_MAX;
      else if (rx_fault_tally != cbf_pkg::REC_MAX)
        rx_fault_tally <= rx_fault_tally + cbf_pkg::REC_STEP_MIN;
    end else if (rx_done) begin
      if (rx_fault_tally > cbf_pkg::REC_HIGH)
        rx_fault_tally <= cbf_pkg::REC_RELOAD;
      else if (rx_fault_tally != 8'h00)
        rx_fault_tally <= rx_fault_tally - cbf_pkg::REC_STEP_MIN;
    end
  end

  // Outputs toward the protocol core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_frame  <= '0;
      tx_irq    <= 1'b0;
      rx_stored <= 1'b0;
    end else begin
      if (state == CBF_IDLE && tx_start)
        tx_frame <= buf_frame[tx_sel];
      tx_irq    <= early_transmit_mode ? (tx_arb_won && state == CBF_TX) : (tx_done && state == CBF_TX);
      rx_stored <= |rx_fill_ok;
    end
  end

  // Combinational status from lock, ready and the error counters toward the link side
  assign tx_request    = lock & ready;
  assign bus_off       = tx_fault_tally >= cbf_pkg::TEC_BUS_OFF;
  assign error_passive = !bus_off && (tx_fault_tally[7:0] > cbf_pkg::PASSIVE_LIMIT ||
                                      rx_fault_tally > cbf_pkg::PASSIVE_LIMIT);

endmodule // cbf_core

/* File: tb/cbf_core_monitor.sv */
// Checker for the buffer, filter and fault counter block
`timescale 1ns/100ps
module cbf_core_monitor (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire cbf_pkg::cbf_fault_ev_s fault_ev,
  input wire logic                   rx_done,
  input wire logic                   rx_stored,
  input wire logic                   tx_arb_won,
  input wire logic                   tx_done,
  input wire logic [2:0]             tx_request,
  input wire logic                   tx_irq,
  input wire logic [2:0]             receive_irq_flag,
  input wire logic                   error_passive,
  input wire logic                   bus_off
);
  logic [8:0] tec_m;
  logic [7:0] rec_m;
  logic [7:0] rec_step;
  logic       acc;
  logic       wr_d7;
  logic       wr_bcsr0;
  assign acc      = psel && penable;
  assign wr_d7    = acc && pwrite && paddr == cbf_pkg::OFS_BUF_BASE + cbf_pkg::OFS_DATA0 + 12'h01C;
  assign wr_bcsr0 = acc && pwrite && paddr == cbf_pkg::OFS_BUF_BASE + cbf_pkg::OFS_BCSR;
  assign rec_step = fault_ev.rx_err_severe ? cbf_pkg::REC_STEP_MAX : cbf_pkg::REC_STEP_MIN;
  // Reference counters; an error wins over a success in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tec_m <= '0;
    else if (tec_m == cbf_pkg::TEC_BUS_OFF) tec_m <= tec_m;
    else if (fault_ev.tx_err) tec_m <= (tec_m > 9'h0F8) ? cbf_pkg::TEC_BUS_OFF : tec_m + cbf_pkg::TEC_STEP_ERR;
    else if (fault_ev.tx_ok && tec_m != 9'h000) tec_m <= tec_m - 9'h001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rec_m <= '0;
    else if (fault_ev.rx_err) rec_m <= (rec_m > cbf_pkg::REC_MAX - rec_step) ? cbf_pkg::REC_MAX : rec_m + rec_step;
    else if (rx_done && rec_m > cbf_pkg::REC_HIGH) rec_m <= cbf_pkg::REC_RELOAD;
    else if (rx_done && rec_m != 8'h00) rec_m <= rec_m - 8'h01;
  end
  sequence s_one_shot;
    tx_irq ##1 !tx_irq;
  endsequence
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_TEC_READ: assert property (acc && !pwrite && paddr == cbf_pkg::OFS_TEC |-> prdata[7:0] == tec_m[7:0])
    else $error("tx error count read wrong");
  AST_REC_READ: assert property (acc && !pwrite && paddr == cbf_pkg::OFS_REC |-> prdata[7:0] == rec_m)
    else $error("rx error count read wrong");
  AST_PASSIVE: assert property (!bus_off |-> error_passive == (tec_m > 9'h07F || rec_m > cbf_pkg::PASSIVE_LIMIT))
    else $error("error passive wrong");
  AST_BUS_OFF: assert property (bus_off == (tec_m == cbf_pkg::TEC_BUS_OFF))
    else $error("bus off wrong");
  AST_RX_STORED: assert property (rx_stored |-> $past(rx_done) && receive_irq_flag != 3'h0)
    else $error("store without reception");
  AST_TX_REQ_CAUSE: assert property ($rose(tx_request[0]) |-> $past(wr_d7))
    else $error("transmit request without last byte write");
  AST_TX_REQ_DROP: assert property ($fell(tx_request[0]) |-> $past(tx_done || wr_bcsr0))
    else $error("transmit request dropped without cause");
  AST_TX_IRQ_CAUSE: assert property (tx_irq |-> $past(tx_done || tx_arb_won))
    else $error("transmit interrupt without cause");
  AST_TX_IRQ_PULSE: assert property (tx_irq |-> s_one_shot)
    else $error("transmit interrupt too long");
  AST_APB_READY: assert property (acc |-> pready)
    else $error("access phase without ready");
endmodule // cbf_core_monitor
bind cbf_core cbf_core_monitor i_cbf_core_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .fault_ev(fault_ev), .rx_done(rx_done),
  .rx_stored(rx_stored), .tx_arb_won(tx_arb_won), .tx_done(tx_done), .tx_request(tx_request), .tx_irq(tx_irq),
  .receive_irq_flag(receive_irq_flag), .error_passive(error_passive), .bus_off(bus_off));

/* File: tb/cbf_can_node.sv */
// Model of the CAN core and bus side that feeds the block
`timescale 1ns/100ps
module cbf_can_node (
  input  wire logic              pclk,
  output cbf_pkg::cbf_fault_ev_s fault_ev,
  output logic                   rx_start,
  output logic [11:0]            rx_key,
  output logic                   rx_done,
  output logic                   rx_abort,
  output cbf_pkg::cbf_frame_s    rx_frame,
  output logic                   tx_start,
  output logic [1:0]             tx_sel,
  output logic                   tx_arb_won,
  output logic                   tx_done,
  output logic                   tx_abort
);
  initial begin
    {rx_start, rx_done, rx_abort, tx_start, tx_arb_won, tx_done, tx_abort} = '0;
    fault_ev = '0;
    rx_key = '0;
    rx_frame = '0;
    tx_sel = '0;
  end
  task automatic rx_begin(input logic [11:0] key);
    @(posedge pclk);
    rx_start <= 1'b1;
    rx_key <= key;
    @(posedge pclk);
    rx_start <= 1'b0;
    rx_key <= ~key;
  endtask
  // Frame is only valid with the done or abort pulse; inverted afterwards
  task automatic rx_end(input cbf_pkg::cbf_frame_s f, input logic ok);
    repeat (2) @(posedge pclk);
    rx_frame <= f;
    rx_done <= ok;
    rx_abort <= !ok;
    @(posedge pclk);
    rx_done <= 1'b0;
    rx_abort <= 1'b0;
    rx_frame <= ~f;
  endtask
  task automatic transmit(input logic [1:0] sel);
    @(posedge pclk);
    tx_start <= 1'b1;
    tx_sel <= sel;
    @(posedge pclk);
    tx_start <= 1'b0;
    tx_sel <= ~sel;
    repeat (2) @(posedge pclk);
    tx_arb_won <= 1'b1;
    @(posedge pclk);
    tx_arb_won <= 1'b0;
    repeat (3) @(posedge pclk);
    tx_done <= 1'b1;
    fault_ev.tx_ok <= 1'b1;
    @(posedge pclk);
    tx_done <= 1'b0;
    fault_ev.tx_ok <= 1'b0;
  endtask
  task automatic fault(input cbf_pkg::cbf_fault_ev_s ev, input int n);
    repeat (n) begin
      @(posedge pclk);
      fault_ev <= ev;
      @(posedge pclk);
      fault_ev <= '0;
    end
  endtask
endmodule // cbf_can_node

/* File: tb/cbf_core_tb.sv */
// Register level test of the buffer, filter and fault counter block
`timescale 1ns/100ps
module cbf_core_tb;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0]            paddr, rx_key;
  logic [31:0]            pwdata, prdata, rdat;
  logic [2:0]             tx_request, receive_irq_flag, receive_irq_flag_clear;
  logic [1:0]             tx_sel;
  logic                   rx_start, rx_done, rx_abort, rx_stored, tx_start, tx_arb_won, tx_done, tx_abort;
  logic                   tx_irq, error_passive, bus_off;
  cbf_pkg::cbf_fault_ev_s fault_ev;
  cbf_pkg::cbf_frame_s    rx_frame, tx_frame;
  int                     n_fail, checks, n_irq, n_rx;
  localparam cbf_pkg::cbf_frame_s FRAME_A = {11'h5A3, 1'b1, 4'h8, 64'h8877665544332211};
  localparam cbf_pkg::cbf_frame_s FRAME_B = {11'h123, 1'b0, 4'h2, 64'h0000000000000A0B};
  localparam logic [11:0] D7 = cbf_pkg::OFS_BUF_BASE + cbf_pkg::OFS_DATA0 + 12'h01C;
  localparam logic [11:0] CS0 = cbf_pkg::OFS_BUF_BASE + cbf_pkg::OFS_BCSR;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (tx_irq === 1'b1) n_irq++;
  always @(posedge pclk) if (rx_stored === 1'b1) n_rx++;
  cbf_core i_cbf_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_ev(fault_ev),
    .rx_start(rx_start), .rx_key(rx_key), .rx_done(rx_done), .rx_abort(rx_abort), .rx_frame(rx_frame),
    .rx_stored(rx_stored), .tx_start(tx_start), .tx_sel(tx_sel), .tx_arb_won(tx_arb_won), .tx_done(tx_done),
    .tx_abort(tx_abort), .tx_request(tx_request), .tx_frame(tx_frame), .tx_irq(tx_irq),
    .receive_irq_flag(receive_irq_flag), .receive_irq_flag_clear(receive_irq_flag_clear), .error_passive(error_passive), .bus_off(bus_off));
  cbf_can_node i_cbf_can_node (.pclk(pclk), .fault_ev(fault_ev), .rx_start(rx_start), .rx_key(rx_key),
    .rx_done(rx_done), .rx_abort(rx_abort), .rx_frame(rx_frame), .tx_start(tx_start), .tx_sel(tx_sel),
    .tx_arb_won(tx_arb_won), .tx_done(tx_done), .tx_abort(tx_abort));
  function automatic logic [11:0] ba(input int b, input logic [11:0] o);
    return cbf_pkg::OFS_BUF_BASE + cbf_pkg::BUF_STRIDE * b[11:0] + o;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    apb(1'b0, a, 8'h00);
    check(what, {24'h000000, exp}, rdat);
  endtask
  task automatic rx(input cbf_pkg::cbf_frame_s f, input logic ok);
    i_cbf_can_node.rx_begin({f.message_ident, f.rtr});
    i_cbf_can_node.rx_end(f, ok);
  endtask
  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    test_done();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, receive_irq_flag_clear} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(cbf_pkg::OFS_TEC, 8'h00, "tec reset");
    rd(cbf_pkg::OFS_REC, 8'h00, "rec reset");
    rd(CS0, 8'h00, "ctrl reset");
    apb(1'b0, 12'hFFC, 8'h00);
    check("unmapped", 32'h00000001, {31'h0, perr});
    i_cbf_can_node.fault(4'b0011, 17);
    i_cbf_can_node.fault(4'b0010, 1);
    rd(cbf_pkg::OFS_REC, 8'h89, "rec errors");
    check("passive rec", 32'h00000001, {31'h0, error_passive});
    // Filter zero takes FRAME_A and ignores the remote bit; filter one left open
    apb(1'b1, cbf_pkg::OFS_FILT_BASE + cbf_pkg::OFS_FLT_HI, 8'hB4);
    apb(1'b1, cbf_pkg::OFS_FILT_BASE + cbf_pkg::OFS_FLT_LO, 8'h60);
    apb(1'b1, cbf_pkg::OFS_FILT_BASE + cbf_pkg::OFS_MSK_HI, 8'hFF);
    apb(1'b1, cbf_pkg::OFS_FILT_BASE + cbf_pkg::OFS_MSK_LO, 8'hE0);
    rx(FRAME_A, 1'b1);
    rd(CS0, 8'h04, "ctrl0 filter0");
    rd(ba(0, cbf_pkg::OFS_ID_HI), FRAME_A.message_ident[10:3], "id hi");
    rd(ba(0, cbf_pkg::OFS_ID_LO), {FRAME_A.message_ident[2:0], FRAME_A.rtr, FRAME_A.dlc}, "id lo");
    rd(D7, FRAME_A.payload[63:56], "last_payload_byte");
    rd(cbf_pkg::OFS_REC, cbf_pkg::REC_RELOAD, "rec reload");
    rx(FRAME_B, 1'b1);
    rd(ba(1, cbf_pkg::OFS_BCSR), 8'h0C, "ctrl1 filter1");
    rd(ba(1, cbf_pkg::OFS_ID_LO), {FRAME_B.message_ident[2:0], FRAME_B.rtr, FRAME_B.dlc}, "id lo data");
    i_cbf_can_node.rx_begin({FRAME_B.message_ident, FRAME_B.rtr});
    rd(ba(2, cbf_pkg::OFS_BCSR), 8'h02, "ctrl2 busy");
    apb(1'b1, ba(2, cbf_pkg::OFS_BCSR), 8'h01);
    i_cbf_can_node.rx_end(FRAME_B, 1'b0);
    rd(ba(2, cbf_pkg::OFS_BCSR), 8'h00, "ctrl2 after abort");
    rx(FRAME_A, 1'b1);
    rd(cbf_pkg::OFS_RECEIVE_IRQ_FLAG, 8'h07, "receive_irq_flag all");
    apb(1'b1, CS0, 8'h00);
    rd(CS0, 8'h00, "ctrl0 released");
    rd(cbf_pkg::OFS_RECEIVE_IRQ_FLAG, 8'h06, "receive_irq_flag cleared");
    @(posedge pclk);
    receive_irq_flag_clear <= 3'b010;
    @(posedge pclk);
    receive_irq_flag_clear <= 3'b000;
    rd(ba(1, cbf_pkg::OFS_BCSR), 8'h04, "ctrl1 acc clear");
    apb(1'b1, CS0, 8'h01);
    rx(FRAME_B, 1'b1);
    rd(ba(0, cbf_pkg::OFS_ID_HI), FRAME_A.message_ident[10:3], "locked kept");
    rd(cbf_pkg::OFS_REC, 8'h75, "rec decrement");
    check("stored count", 32'h00000003, n_rx);
    i_cbf_can_node.fault(4'b1000, 1);
    apb(1'b1, D7, 8'h99);
    @(posedge pclk);
    check("tx request", 32'h00000001, {29'h0, tx_request});
    i_cbf_can_node.transmit(2'd0);
    check("tx ident", {21'h0, FRAME_A.message_ident}, {21'h0, tx_frame.message_ident});
    rd(CS0, 8'h01, "ctrl0 normal done");
    rd(cbf_pkg::OFS_TEC, 8'h07, "tec success");
    apb(1'b1, cbf_pkg::OFS_CONFIG, 8'h01);
    apb(1'b1, D7, 8'h99);
    i_cbf_can_node.transmit(2'd0);
    rd(CS0, 8'h00, "ctrl0 early done");
    check("irq count", 32'h00000002, n_irq);
    apb(1'b1, CS0, 8'h01);
    apb(1'b1, D7, 8'h55);
    apb(1'b1, CS0, 8'h00);
    @(posedge pclk);
    check("tx cancel", 32'h00000000, {29'h0, tx_request});
    i_cbf_can_node.fault(4'b1000, 16);
    @(posedge pclk);
    check("passive tec", 32'h00000001, {31'h0, error_passive});
    i_cbf_can_node.fault(4'b1000, 16);
    @(posedge pclk);
    check("bus off", 32'h00000001, {31'h0, bus_off});
    rd(cbf_pkg::OFS_TEC, 8'h00, "tec low byte");
    test_done();
  end
endmodule // cbf_core_tb
